// ### cpu_core_model.sv
`timescale 1ns/10ps
// Behavioural CPU core issuing stop and clear-watchdog instructions
module cpu_core_model #(
  parameter int KICK_GAP = 100
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic doStop,
  input  wire logic doClear,
  input  wire logic kickEn,
  input  wire logic cpuRun,
  output logic      stopInstr,
  output logic      clearWdogInstr
);
  int gap;

  // An asleep core executes nothing, so every instruction waits for cpuRun
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gap            <= 0;
      stopInstr      <= 1'b0;
      clearWdogInstr <= 1'b0;
    end else begin
      gap            <= (kickEn && gap < KICK_GAP - 1) ? gap + 1 : 0;
      stopInstr      <= doStop && cpuRun;
      clearWdogInstr <= cpuRun && (doClear || (kickEn && gap == KICK_GAP - 1));
    end
  end
endmodule

// ### edge_wake.sv
`timescale 1ns/10ps
// Per-pin falling edge detector gated by the wake enable bits
module edge_wake #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] wakeEn,
  output logic                  wakeHit
);
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] fall;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      assign fall[i] = prev_reg[i] & ~pins[i] & wakeEn[i];
    end
  endgenerate

  assign wakeHit = |fall;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= pins;
    end
  end
endmodule

// ### slow_tick.sv
`timescale 1ns/10ps
// Rising edge detector for the low-speed oscillator, sampled on mclk
module slow_tick (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic slowOsc,
  output logic      tick
);
  logic last_reg;

  assign tick = slowOsc & ~last_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= slowOsc;
    end
  end
endmodule

// ### watchdog_wakeup_reset.sv
`timescale 1ns/10ps
// Watchdog timer with key-field reset, reset cause flags and sleep wake-up control

// Functional notes
// - In sleep, wake on enabled port falling edge, interrupt, or watchdog overflow.
// - Stop instruction enters power-down and sets the power-down flag.
// - Power-down flag clears only at power-up or clear-watchdog instruction.
// - Overflow in sleep sets time-out flag, resets only PC and stack pointer.
// - Each port pin has a wake enable; pin wake resumes after stop.
// - Disabled interrupt or full stack: resume after stop, service later.
// - Enabled interrupt with stack not full: normal interrupt response on wake.
// - Interrupt already pending on entering sleep cannot wake the device.
// - Counter runs from low-speed oscillator, divided by 2^8 to 2^18.
// - Watchdog enabled only while key field is 01010B or 10101B.
// - Other key values cause delayed device reset and set soft-reset flag.
// - Key field holds 01010B after power-on.
// - Select 000..110 gives 2^8,2^10,2^12,2^14,2^15,2^16,2^17.
// - Soft-reset flag set by key reset, cleared only at power-up or by program write.
// - Time-out while running gives full reset and sets time-out flag.
// - Counter cleared by key reset, clear-watchdog instruction, or stop.
// - Power-on reset sets the program counter to zero.
// - Low supply while running gives full reset, a distinct reset type.
// - Entering sleep sets power-down, clears time-out and clears the counter.
module watchdog_wakeup_reset
  import wdt_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic [1:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wstrobe,
  input  wire logic            rstrobe,
  output logic      [7:0]      rdata,
  input  wire logic            slowOsc,
  input  wire logic            stopInstr,
  input  wire logic            clearWdogInstr,
  input  wire logic [PINS-1:0] portPins,
  input  wire logic            intRequest,
  input  wire logic            intEnabled,
  input  wire logic            stackFull,
  input  wire logic            lowVoltage,
  output logic                 cpuRun,
  output logic                 intVectorNow,
  output logic                 resumeAfterStop,
  output logic                 fullReset,
  output logic                 pcSpReset,
  output logic                 powerDownFlag,
  output logic                 timeoutStatusFlag
);
  logic [7:0]            ctrl_reg, ctrl_next;
  logic                  lvrFlag_reg, lvrFlag_next;
  logic                  softFlag_reg, softFlag_next;
  logic [PINS-1:0]       wakeEn_reg, wakeEn_next;
  logic                  pdf_reg, pdf_next;
  logic                  tof_reg, tof_next;
  power_e                mode_reg, mode_next;
  logic                  intMask_reg, intMask_next;
  logic [WDOG_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0]            softCnt_reg, softCnt_next;
  logic                  softPend_reg, softPend_next;
  logic [7:0]            rdata_reg, rdata_next;
  logic                  cpuRun_reg, cpuRun_next;
  logic                  intVec_reg, intVec_next;
  logic                  resume_reg, resume_next;
  logic                  fullRst_reg, fullRst_next;
  logic                  pcSp_reg, pcSp_next;

  logic                  pinWake;
  logic                  tick;
  logic                  keyOk;
  logic                  overflow;
  logic [4:0]            divExp;
  logic                  ctrlWrite;

  edge_wake #(.WIDTH(PINS)) u_edge (
    .mclk    (mclk),
    .nrst    (nrst),
    .pins    (portPins),
    .wakeEn  (wakeEn_reg),
    .wakeHit (pinWake)
  );

  slow_tick u_tick (
    .mclk    (mclk),
    .nrst    (nrst),
    .slowOsc (slowOsc),
    .tick    (tick)
  );

  assign keyOk     = (ctrl_reg[KEY_MSB:KEY_LSB] == KEY_ENABLE_A) ||
                     (ctrl_reg[KEY_MSB:KEY_LSB] == KEY_ENABLE_B);
  assign ctrlWrite = wstrobe && (addr == ADDR_WDOG_CTRL);

  // Period exponent per select code
  always_comb begin
    unique case (ctrl_reg[SEL_MSB:0])
      3'h0: divExp = 5'h08;
      3'h1: divExp = 5'h0a;
      3'h2: divExp = 5'h0c;
      3'h3: divExp = 5'h0e;
      3'h4: divExp = 5'h0f;
      3'h5: divExp = 5'h10;
      3'h6: divExp = 5'h11;
      3'h7: divExp = 5'h12;
    endcase
  end

  // Overflow when the count reaches 2^exp - 1 on a slow tick
  assign overflow = keyOk && tick &&
                    (cnt_reg == WDOG_CNT_W'((19'h1 << divExp) - 19'h1));

  always_comb begin
    ctrl_next     = ctrl_reg;
    lvrFlag_next  = lvrFlag_reg;
    softFlag_next = softFlag_reg;
    wakeEn_next   = wakeEn_reg;
    pdf_next      = pdf_reg;
    tof_next      = tof_reg;
    mode_next     = mode_reg;
    intMask_next  = intMask_reg;
    cnt_next      = cnt_reg;
    softCnt_next  = softCnt_reg;
    softPend_next = softPend_reg;
    rdata_next    = 8'h00;
    intVec_next   = 1'b0;
    resume_next   = 1'b0;
    fullRst_next  = 1'b0;
    pcSp_next     = 1'b0;

    // Register writes
    if (wstrobe) begin
      unique case (addr)
        ADDR_WDOG_CTRL: ctrl_next = wdata;
        ADDR_RST_FLAGS: begin
          lvrFlag_next  = wdata[LVR_FLAG_BIT];
          softFlag_next = wdata[SOFT_FLAG_BIT];
        end
        ADDR_WAKE_EN:   wakeEn_next = wdata[PINS-1:0];
        ADDR_STATUS:    ;
      endcase
    end

    // Watchdog counter
    if (tick && keyOk) begin
      cnt_next = cnt_reg + 1'b1;
    end
    if (clearWdogInstr && mode_reg == RUN_S) begin
      cnt_next = '0;
      pdf_next = 1'b0;
      tof_next = 1'b0;
    end

    // Bad key: delayed soft reset
    if (ctrlWrite && !((wdata[KEY_MSB:KEY_LSB] == KEY_ENABLE_A) ||
                       (wdata[KEY_MSB:KEY_LSB] == KEY_ENABLE_B))) begin
      cnt_next = '0;
    end
    if (!keyOk && !softPend_reg) begin
      softPend_next = 1'b1;
      softCnt_next  = SOFT_RESET_CNT;
    end else if (softPend_reg) begin
      if (softCnt_reg == 8'h00) begin
        fullRst_next  = 1'b1;
        softFlag_next = 1'b1;
        softPend_next = 1'b0;
        ctrl_next     = CTRL_RESET;
        cnt_next      = '0;
        mode_next     = RUN_S;
        intMask_next  = 1'b0;
      end else begin
        softCnt_next = softCnt_reg - 8'h01;
      end
    end

    unique case (mode_reg)
      RUN_S: begin
        if (stopInstr) begin
          mode_next    = SLEEP_S;
          pdf_next     = 1'b1;
          tof_next     = 1'b0;
          cnt_next     = '0;
          intMask_next = intRequest;
        end else if (overflow) begin
          fullRst_next = 1'b1;
          tof_next     = 1'b1;
          cnt_next     = '0;
        end
      end
      SLEEP_S: begin
        if (!intRequest) begin
          intMask_next = 1'b0;
        end
        if (overflow) begin
          mode_next = RUN_S;
          tof_next  = 1'b1;
          pcSp_next = 1'b1;
          cnt_next  = '0;
        end else if (intRequest && !intMask_reg) begin
          mode_next = RUN_S;
          if (intEnabled && !stackFull) begin
            intVec_next = 1'b1;
          end else begin
            resume_next = 1'b1;
          end
        end else if (pinWake) begin
          mode_next   = RUN_S;
          resume_next = 1'b1;
        end
      end
      default: mode_next = RUN_S;
    endcase

    // Low voltage reset only acts while running
    if (lowVoltage && mode_reg == RUN_S) begin
      fullRst_next = 1'b1;
      lvrFlag_next = 1'b1;
      ctrl_next    = CTRL_RESET;
      cnt_next     = '0;
      softPend_next = 1'b0;
    end

    if (rstrobe) begin
      unique case (addr)
        ADDR_WDOG_CTRL: rdata_next = ctrl_reg;
        ADDR_RST_FLAGS: rdata_next = {5'h00, lvrFlag_reg, 1'b0, softFlag_reg};
        ADDR_WAKE_EN:   rdata_next = 8'(wakeEn_reg);
        ADDR_STATUS:    rdata_next = {5'h00, mode_reg == SLEEP_S, tof_reg, pdf_reg};
      endcase
    end
  end

  assign cpuRun_next = (mode_next == RUN_S);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= CTRL_RESET;
      lvrFlag_reg  <= 1'b0;
      softFlag_reg <= 1'b0;
      wakeEn_reg   <= '0;
      pdf_reg      <= 1'b0;
      tof_reg      <= 1'b0;
      mode_reg     <= RUN_S;
      intMask_reg  <= 1'b0;
      cnt_reg      <= '0;
      softCnt_reg  <= 8'h00;
      softPend_reg <= 1'b0;
      rdata_reg    <= 8'h00;
      cpuRun_reg   <= 1'b1;
      intVec_reg   <= 1'b0;
      resume_reg   <= 1'b0;
      fullRst_reg  <= 1'b0;
      pcSp_reg     <= 1'b1;
    end else begin
      ctrl_reg     <= ctrl_next;
      lvrFlag_reg  <= lvrFlag_next;
      softFlag_reg <= softFlag_next;
      wakeEn_reg   <= wakeEn_next;
      pdf_reg      <= pdf_next;
      tof_reg      <= tof_next;
      mode_reg     <= mode_next;
      intMask_reg  <= intMask_next;
      cnt_reg      <= cnt_next;
      softCnt_reg  <= softCnt_next;
      softPend_reg <= softPend_next;
      rdata_reg    <= rdata_next;
      cpuRun_reg   <= cpuRun_next;
      intVec_reg   <= intVec_next;
      resume_reg   <= resume_next;
      fullRst_reg  <= fullRst_next;
      pcSp_reg     <= pcSp_next;
    end
  end

  assign rdata             = rdata_reg;
  assign cpuRun            = cpuRun_reg;
  assign intVectorNow      = intVec_reg;
  assign resumeAfterStop   = resume_reg;
  assign fullReset         = fullRst_reg;
  assign pcSpReset         = pcSp_reg;
  assign powerDownFlag     = pdf_reg;
  assign timeoutStatusFlag = tof_reg;

  stop_sets_pdf_a: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_reg == RUN_S && stopInstr) |=> (powerDownFlag && !timeoutStatusFlag && !cpuRun))
    else $error("stop did not enter power-down");
  clr_pdf_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(powerDownFlag) |-> $past(clearWdogInstr))
    else $error("power-down flag cleared without clear instruction");
  sleep_wdt_a: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_reg == SLEEP_S && overflow) |=> (pcSpReset && !fullReset && timeoutStatusFlag))
    else $error("sleep overflow wrong reset");
  int_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_reg == SLEEP_S && !overflow && intRequest && !intMask_reg && intEnabled
     && !stackFull) |=> intVectorNow)
    else $error("interrupt wake missed vector");
  pend_int_a: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_reg == RUN_S && stopInstr && intRequest) ##1 (intRequest && !pinWake && !overflow)
    |=> !cpuRun)
    else $error("pending interrupt woke device");
  key_enable_a: assert property (@(posedge mclk) disable iff (!nrst)
    !keyOk |-> ##1 (cnt_reg == $past(cnt_reg) || cnt_reg == '0))
    else $error("counter ran with bad key");
  soft_rst_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!keyOk && !softPend_reg && !lowVoltage) |-> ##[1:20] (fullReset && softFlag_reg))
    else $error("bad key did not reset");
  run_timeout_a: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_reg == RUN_S && overflow && !stopInstr) |=> (fullReset && timeoutStatusFlag))
    else $error("run overflow did not reset");
endmodule

// ### watchdog_wakeup_reset_bench.sv
`timescale 1ns/10ps
// Self-checking bench for the watchdog and wake-up block
module watchdog_wakeup_reset_bench;
  import wdt_pkg::*;
  localparam int LIMIT = 70000;
  logic       mclk, nrst, wstrobe, rstrobe, slowOsc, stopInstr, clearWdogInstr;
  logic       intRequest, intEnabled, stackFull, lowVoltage, doStop, doClear, kickEn;
  logic       cpuRun, intVectorNow, resumeAfterStop, fullReset, pcSpReset;
  logic       powerDownFlag, timeoutStatusFlag, live, rdPend;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, portPins;
  logic [4:0] key;
  logic [7:0] rdQ[$];
  logic [3:0] evQ[$];
  int         miscompares, checked, cycles, i, p;

  watchdog_wakeup_reset #(.PINS(8)) watchdog_wakeup_reset_inst (
    .mclk, .nrst, .addr, .wdata, .wstrobe, .rstrobe, .rdata, .slowOsc, .stopInstr,
    .clearWdogInstr, .portPins, .intRequest, .intEnabled, .stackFull, .lowVoltage,
    .cpuRun, .intVectorNow, .resumeAfterStop, .fullReset, .pcSpReset, .powerDownFlag,
    .timeoutStatusFlag
  );

  cpu_core_model #(.KICK_GAP(100)) cpu_core_model_inst (
    .mclk, .nrst, .doStop, .doClear, .kickEn, .cpuRun, .stopInstr, .clearWdogInstr
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Low-speed oscillator, one rising edge every two fast cycles
  always @(posedge mclk) slowOsc <= ~slowOsc;

  task automatic complete_run();
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Any wake or reset pulse must match the oldest expected event
  always @(posedge mclk) begin
    if (live && rdPend)
      compare(rdata, rdQ.size() ? rdQ.pop_front() : 8'hxx);
    if (live && {fullReset, pcSpReset, resumeAfterStop, intVectorNow} !== 4'h0)
      compare({4'h0, fullReset, pcSpReset, resumeAfterStop, intVectorNow},
              {4'h0, evQ.size() ? evQ.pop_front() : 4'h0});
    live   <= nrst;
    rdPend <= rstrobe;
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wdata   <= d;
    wstrobe <= 1'b1;
    @(posedge mclk);
    wstrobe <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr    <= a;
    rstrobe <= 1'b1;
    rdQ.push_back(e);
    @(posedge mclk);
    rstrobe <= 1'b0;
  endtask

  // Expect one event after lead cycles, allowing span cycles for it
  task automatic ev(input logic [3:0] e, input int lead, input int span);
    repeat (lead) @(posedge mclk);
    #1;
    evQ.push_back(e);
    repeat (span) if (evQ.size() != 0) @(posedge mclk);
    #1;
    if (evQ.size() != 0)
      compare(8'h00, {4'h0, evQ.pop_front()});
  endtask

  task automatic pulse_cmd(input logic stop);
    @(posedge mclk);
    doStop  <= stop;
    doClear <= !stop;
    @(posedge mclk);
    doStop  <= 1'b0;
    doClear <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    nrst = 1'b0;
    {addr, wdata, wstrobe, rstrobe, slowOsc, doStop, doClear, kickEn} = '0;
    {intRequest, intEnabled, stackFull, lowVoltage, live, rdPend} = '0;
    portPins = 8'hff;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(54));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(ADDR_WDOG_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE_B, 3'h2});
    rd(ADDR_WDOG_CTRL, {KEY_ENABLE_B, 3'h2});
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    repeat (20) @(posedge mclk);
    // Shortest period, kept alive by the core's periodic clears
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE_A, 3'h0});
    kickEn <= 1'b1;
    repeat (1500) @(posedge mclk);
    kickEn <= 1'b0;
    do key = 5'($urandom()); while (key == KEY_ENABLE_A || key == KEY_ENABLE_B);
    wr(ADDR_WDOG_CTRL, {key, 3'h1});
    ev(4'h8, SOFT_RESET_CYC - 2, 8);
    rd(ADDR_RST_FLAGS, 8'h01);
    rd(ADDR_WDOG_CTRL, CTRL_RESET);
    wr(ADDR_RST_FLAGS, 8'h00);
    rd(ADDR_RST_FLAGS, 8'h00);
    p = $urandom_range(7, 0);
    wr(ADDR_WAKE_EN, 8'h01 << p);
    rd(ADDR_WAKE_EN, 8'h01 << p);
    pulse_cmd(1'b1);
    rd(ADDR_STATUS, 8'h05);
    // Disabled pins fall first and must not wake
    @(posedge mclk) portPins <= 8'h01 << p;
    repeat (8) @(posedge mclk);
    @(posedge mclk) portPins <= 8'h00;
    ev(4'h2, 0, 4);
    @(posedge mclk) portPins <= 8'hff;
    for (i = 0; i < 3; i++) begin
      intEnabled <= (i != 1);
      stackFull  <= (i == 2);
      pulse_cmd(1'b1);
      @(posedge mclk) intRequest <= 1'b1;
      ev((i == 0) ? 4'h1 : 4'h2, 0, 4);
      @(posedge mclk) intRequest <= 1'b0;
    end
    // A request already pending at sleep entry must not wake
    stackFull  <= 1'b0;
    intRequest <= 1'b1;
    pulse_cmd(1'b1);
    repeat (10) @(posedge mclk);
    @(posedge mclk) intRequest <= 1'b0;
    @(posedge mclk) intRequest <= 1'b1;
    ev(4'h1, 0, 4);
    @(posedge mclk) intRequest <= 1'b0;
    pulse_cmd(1'b0);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE_A, 3'h0});
    pulse_cmd(1'b1);
    ev(4'h4, 496, 24);
    rd(ADDR_STATUS, 8'h03);
    pulse_cmd(1'b0);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_WDOG_CTRL, {KEY_ENABLE_A, 3'(i)});
      pulse_cmd(1'b0);
      ev(4'h8, (2 << (8 + 2 * i)) - 16, 24);
      rd(ADDR_STATUS, 8'h02);
    end
    // Low supply while running gives a full reset and its own flag
    @(posedge mclk) lowVoltage <= 1'b1;
    @(posedge mclk) lowVoltage <= 1'b0;
    ev(4'h8, 0, 4);
    rd(ADDR_RST_FLAGS, 8'h04);
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule

// ### wdt_pkg.sv
// Package: constants for the watchdog and wake-up block
package wdt_pkg;
  localparam logic [1:0] ADDR_WDOG_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_RST_FLAGS  = 2'h1;
  localparam logic [1:0] ADDR_WAKE_EN    = 2'h2;
  localparam logic [1:0] ADDR_STATUS     = 2'h3;
  localparam logic [7:0] CTRL_RESET      = 8'h53;
  localparam logic [4:0] KEY_ENABLE_A    = 5'h0a;
  localparam logic [4:0] KEY_ENABLE_B    = 5'h15;
  localparam int         KEY_MSB         = 7;
  localparam int         KEY_LSB         = 3;
  localparam int         SEL_MSB         = 2;
  localparam int         LVR_FLAG_BIT    = 2;
  localparam int         SOFT_FLAG_BIT   = 0;
  localparam int         PDF_BIT         = 0;
  localparam int         TOF_BIT         = 1;
  localparam int         ASLEEP_BIT      = 2;
  localparam int         WDOG_CNT_W      = 18;
  // Soft reset delay in ns, and its cycle count at the 10 ns clock
  localparam int         SOFT_RESET_NS   = 100;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         SOFT_RESET_CYC  = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SOFT_RESET_CNT  = 8'(SOFT_RESET_CYC);
  typedef enum logic [1:0] {
    RUN_S   = 2'b00,
    SLEEP_S = 2'b01
  } power_e;
endpackage
